// file: hw/voltage_pwm_autotune_status.v
// Driver status flags and two phase automatic tuning of the PWM chopper
// Behaviour
// - bits 9 and 8 follow temperature comparators
// - open load bits 7,6 informational only
// - low-side short sets bit 5/4, disables
// - ground short sets bit 3/2, disables
// - shorts latched until off-time zero or disable
// - separate short storage per chopper mode
// - overheat bit 1 holds disable until prewarn clears
// - bit 0 prewarn; single shared flags
// - offset phase at standstill, run current, bounded
// - first step returns to run current
// - gradient phase within scale window only
// - gradient moves one unit per 8 fullsteps
// - gradient waits for offset phase completion
// - preloaded gradient makes second phase optional
// - tuning reruns when conditions recur after motion
// - supply change invalidates until new offset phase
// - standstill after 2^20 clocks without step
`timescale 1ns/1ns
`default_nettype none
`include "autotune_status_map.vh"
module voltage_pwm_autotune_status #(
  parameter [31:0] STANDSTILL_CLKS = `STANDSTILL_CLKS,
  parameter [31:0] OFFSET_PHASE_CLKS = `OFFSET_PHASE_CLKS,
  parameter [3:0] STEPS_PER_UNIT = `FULLSTEPS_PER_GRAD
) (
  input wire clk,
  input wire rst,
  // Temperature comparators
  input wire temp_cmp_high_mid,
  input wire temp_cmp_low,
  input wire overheat_cmp,
  input wire prewarn_cmp,
  // Fault detectors, one-cycle or level
  input wire open_load_b,
  input wire open_load_a,
  input wire lowside_short_phase_b,
  input wire lowside_short_phase_a,
  input wire ground_short_phase_b,
  input wire ground_short_phase_a,
  // Configuration
  input wire [3:0] chopper_off_time_setting,
  input wire driver_disable_pin,
  input wire powerdown_serial_pin,
  input wire voltage_mode,
  input wire [4:0] run_current_setting,
  input wire [4:0] hold_current_setting,
  // Motion and regulator
  input wire step_pulse,
  input wire fullstep,
  input wire [8:0] summed_amplitude_scale,
  input wire [7:0] measured_offset,
  input wire supply_changed,
  input wire grad_load,
  input wire [7:0] grad_load_value,
  input wire grad_up,
  input wire grad_down,
  // Outputs
  output wire [31:0] driver_status_flags,
  output reg bridge_enable,
  output wire standstill,
  output reg [4:0] current_scale,
  output reg [7:0] auto_amplitude_offset,
  output wire [7:0] auto_amplitude_gradient,
  output reg tuning_phase_offset,
  output reg tuning_phase_gradient,
  output reg offset_valid
);
  ////////////////////////////////////////////////////////////////
  // Tuning states
  localparam [1:0] ST_WAIT = 2'h0;
  localparam [1:0] ST_OFFSET = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;
  // WAIT: no usable standstill at run current yet
  // OFFSET: measuring, aborted by any motion
  // DONE: result stored, rerun after next motion

  // Latched short flags, one set per chopper mode
  reg [3:0] short_voltage_q;
  reg [3:0] short_current_q;
  // Shared overheat latch
  reg overheat_q;
  // Registered live flags
  reg temp_hi_q;
  reg temp_lo_q;
  reg open_b_q;
  reg open_a_q;
  reg prewarn_q;
  // Tuning state and timer
  reg [1:0] state_q;
  reg [31:0] phase_cnt_q;
  // Short flags in the active mode
  wire [3:0] short_sel;
  wire short_clear;
  wire [3:0] short_in;
  wire stst;
  wire at_run;
  wire [9:0] ofs_x4;
  wire [9:0] ofs_x15;
  wire [9:0] scale_x2;
  wire grad_window;
  // Offset phase finishes this cycle
  wire offset_done;
  // Run current held after a step until the offset phase ends
  reg tune_hold_q;

  ////////////////////////////////////////////////////////////////
  // Standstill detection
  standstill_timer #(
    .STANDSTILL_CLKS(STANDSTILL_CLKS)
  ) u_stst (
    .clk(clk),
    .rst(rst),
    .step_pulse(step_pulse),
    .standstill(stst)
  );
  assign standstill = stst;

  ////////////////////////////////////////////////////////////////
  // Live flag registers
  // Comparator and open-load inputs are levels from the analog side.
  // One register stage gives a clean word to the serial read path;
  // nothing here latches, so a read always shows the present state.
  always @(posedge clk) begin
    if (rst) begin
      temp_hi_q <= 1'b0;
      temp_lo_q <= 1'b0;
      open_b_q <= 1'b0;
      open_a_q <= 1'b0;
      prewarn_q <= 1'b0;
    end else begin
      temp_hi_q <= temp_cmp_high_mid;
      temp_lo_q <= temp_cmp_low;
      open_b_q <= open_load_b;
      open_a_q <= open_load_a;
      prewarn_q <= prewarn_cmp;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Short flags: {ls_b, ls_a, gnd_b, gnd_a}
  // Short detectors may pulse for a single cycle only, so the flags
  // are latched. Each chopper mode owns its own set: a fault found in
  // one mode stays stored while the other mode runs, and is shown
  // again once that mode is selected. A clear hits both sets at once.
  assign short_in = {lowside_short_phase_b, lowside_short_phase_a,
                     ground_short_phase_b, ground_short_phase_a};
  // clear on zero off-time or disable pin
  assign short_clear = (chopper_off_time_setting == 4'h0) || driver_disable_pin;

  // one latch set per chopper mode
  always @(posedge clk) begin
    if (rst) begin
      short_voltage_q <= 4'h0;
      short_current_q <= 4'h0;
    end else begin
      // Set wins over clear
      if (voltage_mode)
        short_voltage_q <= short_in | (short_clear ? 4'h0 : short_voltage_q);
      else if (short_clear)
        short_voltage_q <= 4'h0;
      if (!voltage_mode)
        short_current_q <= short_in | (short_clear ? 4'h0 : short_current_q);
      else if (short_clear)
        short_current_q <= 4'h0;
    end
  end
  assign short_sel = voltage_mode ? short_voltage_q : short_current_q;

  ////////////////////////////////////////////////////////////////
  // Overheat latch
  // The latch is shared by both bridges. It falls only once the die
  // has cooled below the prewarning level, which gives the hysteresis
  // that keeps the bridges from toggling at the threshold.
  always @(posedge clk) begin
    if (rst) begin
      overheat_q <= 1'b0;
    end else if (overheat_cmp) begin
      overheat_q <= 1'b1;
    end else if (!prewarn_cmp) begin
      overheat_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bridge enable
  // Raw short inputs are used as well as the latches, so the bridges
  // drop in the same cycle that the fault flag is stored. Open-load
  // and prewarning flags are deliberately left out of this term.
  always @(posedge clk) begin
    if (rst) begin
      bridge_enable <= 1'b0;
    end else begin
      bridge_enable <= (short_sel == 4'h0) && (short_in == 4'h0) && !overheat_q &&
                       !overheat_cmp && !driver_disable_pin &&
                       (chopper_off_time_setting != 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status word, read-only
  // Upper bits are not covered by this block and read as zero.
  // The word is pure wiring from registers: a read cannot clear it.
  // reading has no side effect
  assign driver_status_flags = {22'h00_0000, temp_hi_q, temp_lo_q, open_b_q, open_a_q,
                                short_sel, overheat_q, prewarn_q};

  ////////////////////////////////////////////////////////////////
  // Current scale selection
  // With reduction enabled the drive falls to hold current at
  // standstill. A step raises it again and keeps it up until the
  // offset phase has measured at run current; the offset would be
  // wrong if it were taken at the reduced level.
  // a step holds run current until offset phase ends
  always @(posedge clk) begin
    if (rst) begin
      tune_hold_q <= 1'b0;
    end else if (step_pulse) begin
      tune_hold_q <= 1'b1;
    end else if (offset_done) begin
      tune_hold_q <= 1'b0;
    end
  end

  // Drive level: run or hold
  always @(posedge clk) begin
    if (rst) begin
      current_scale <= 5'h00;
    // step returns drive to run current
    end else if (step_pulse || !stst || powerdown_serial_pin || tune_hold_q) begin
      current_scale <= run_current_setting;
    end else begin
      current_scale <= hold_current_setting;
    end
  end
  assign at_run = (current_scale == run_current_setting);

  ////////////////////////////////////////////////////////////////
  // Offset phase sequencer
  // The phase restarts from zero whenever motion or a current change
  // interrupts it; a partial measurement is never kept. A supply
  // change drops the valid flag, which stops gradient tuning until a
  // fresh offset result exists.
  // bounded completion at standstill and run current
  assign offset_done = (state_q == ST_OFFSET) && stst && at_run &&
                       (phase_cnt_q >= OFFSET_PHASE_CLKS - 32'h0000_0001);

  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_WAIT;
      phase_cnt_q <= 32'h0000_0000;
      auto_amplitude_offset <= `OFS_DEFAULT;
      offset_valid <= 1'b0;
      tuning_phase_offset <= 1'b0;
    end else begin
      if (supply_changed)
        offset_valid <= 1'b0;
      case (state_q)
        ST_WAIT: begin
          if (stst && at_run) begin
            state_q <= ST_OFFSET;
            phase_cnt_q <= 32'h0000_0000;
            tuning_phase_offset <= 1'b1;
          end
        end
        ST_OFFSET: begin
          if (!stst || !at_run) begin
            // Aborted by motion
            state_q <= ST_WAIT;
            tuning_phase_offset <= 1'b0;
          end else if (offset_done) begin
            auto_amplitude_offset <= measured_offset;
            offset_valid <= 1'b1;
            tuning_phase_offset <= 1'b0;
            state_q <= ST_DONE;
          end else begin
            phase_cnt_q <= phase_cnt_q + 32'h0000_0001;
          end
        end
        ST_DONE: begin
          if (!stst)
            state_q <= ST_WAIT;
        end
        default: begin
          state_q <= ST_WAIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Gradient window: 1.5*ofs < sum < 4*ofs, sum < 255
  // Compared at twice the scale so that the factor of one and a half
  // needs no fractions; the offset and scale terms are ten bits wide to avoid overflow.
  assign ofs_x4 = {auto_amplitude_offset, 2'b00};
  assign ofs_x15 = {1'b0, auto_amplitude_offset, 1'b0} + {2'b00, auto_amplitude_offset};
  assign scale_x2 = {summed_amplitude_scale, 1'b0};
  assign grad_window = (scale_x2 > ofs_x15) &&
                       ({1'b0, summed_amplitude_scale} < ofs_x4) &&
                       (summed_amplitude_scale < `SCALE_LIMIT);

  always @(posedge clk) begin
    if (rst) begin
      tuning_phase_gradient <= 1'b0;
    end else begin
      tuning_phase_gradient <= offset_valid && !stst && grad_window;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Gradient adaptation
  // A preload from a prior result lets motion start well tuned; the
  // adapter keeps refining it whenever the gradient phase is open.
  // preload from prior result
  gradient_adapter #(
    .STEPS_PER_UNIT(STEPS_PER_UNIT)
  ) u_grad (
    .clk(clk),
    .rst(rst),
    .load(grad_load),
    .load_value(grad_load_value),
    .enable(tuning_phase_gradient),
    .fullstep(fullstep),
    .up_req(grad_up),
    .down_req(grad_down),
    .gradient(auto_amplitude_gradient)
  );
endmodule
`default_nettype wire

// file: hw/autotune_status_map.vh
// Constants for the driver status flags and automatic tuning block
`ifndef AUTOTUNE_STATUS_MAP_VH
`define AUTOTUNE_STATUS_MAP_VH

// Status word bit positions
`define BIT_TEMP_HIGH_MID 9
`define BIT_TEMP_LOW 8
`define BIT_OPEN_B 7
`define BIT_OPEN_A 6
`define BIT_LS_SHORT_B 5
`define BIT_LS_SHORT_A 4
`define BIT_GND_SHORT_B 3
`define BIT_GND_SHORT_A 2
`define BIT_OVERHEAT 1
`define BIT_PREWARN 0

// Timing in device clocks, gradient group size in fullsteps
`define STANDSTILL_CLKS 32'h0010_0000
`define OFFSET_PHASE_CLKS 32'h0018_0000
`define FULLSTEPS_PER_GRAD 4'h8

// Reset values and scale window limit
`define GRAD_DEFAULT 8'h0e
`define OFS_DEFAULT 8'h24
`define SCALE_LIMIT 9'h0ff

`endif

// file: hw/standstill_timer.v
// Standstill detector: counts clocks since the last step pulse
`timescale 1ns/1ns
`default_nettype none
`include "autotune_status_map.vh"
module standstill_timer #(
  parameter [31:0] STANDSTILL_CLKS = `STANDSTILL_CLKS
) (
  input wire clk,
  input wire rst,
  input wire step_pulse,
  output reg standstill
);
  // Clocks since the last step
  reg [31:0] count_q;

  ////////////////////////////////////////////////////////////////
  // standstill after idle count
  always @(posedge clk) begin
    if (rst || step_pulse) begin
      count_q <= 32'h0000_0000;
      standstill <= 1'b0;
    end else if (count_q >= STANDSTILL_CLKS - 32'h0000_0001) begin
      // Saturate
      standstill <= 1'b1;
    end else begin
      count_q <= count_q + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// file: hw/gradient_adapter.v
// Gradient adaptation: moves gradient one unit per group of fullsteps
`timescale 1ns/1ns
`default_nettype none
`include "autotune_status_map.vh"
module gradient_adapter #(
  parameter [3:0] STEPS_PER_UNIT = `FULLSTEPS_PER_GRAD
) (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [7:0] load_value,
  input wire enable,
  input wire fullstep,
  input wire up_req,
  input wire down_req,
  output reg [7:0] gradient
);
  // Fullsteps seen in the current group, cleared by load, disable or a full group
  reg [3:0] steps_q;

  ////////////////////////////////////////////////////////////////
  // one unit per eight fullsteps
  always @(posedge clk) begin
    if (rst) begin
      gradient <= `GRAD_DEFAULT;
      steps_q <= 4'h0;
    end else if (load) begin
      // Preset from a prior result
      gradient <= load_value;
      steps_q <= 4'h0;
    end else if (!enable) begin
      steps_q <= 4'h0;
    end else if (fullstep) begin
      if (steps_q >= STEPS_PER_UNIT - 4'h1) begin
        steps_q <= 4'h0;
        if (up_req && gradient != 8'hff)
          gradient <= gradient + 8'h01;
        else if (down_req && gradient != 8'h00)
          gradient <= gradient - 8'h01;
      end else begin
        steps_q <= steps_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/autotune_status_properties.sv
// Checker of status flag, protection and tuning timing
`timescale 1ns/1ns
`default_nettype none
module autotune_checker #(
  parameter [31:0] STANDSTILL_CLKS = 32'h0010_0000
) (
  input wire clk,
  input wire rst,
  input wire temp_cmp_high_mid,
  input wire temp_cmp_low,
  input wire overheat_cmp,
  input wire prewarn_cmp,
  input wire lowside_short_phase_b,
  input wire lowside_short_phase_a,
  input wire ground_short_phase_b,
  input wire ground_short_phase_a,
  input wire [3:0] chopper_off_time_setting,
  input wire driver_disable_pin,
  input wire voltage_mode,
  input wire step_pulse,
  input wire grad_load,
  input wire [31:0] driver_status_flags,
  input wire bridge_enable,
  input wire standstill,
  input wire [7:0] auto_amplitude_gradient,
  input wire tuning_phase_gradient
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [31:0] sf = driver_status_flags; // Short alias
  wire [7:0] g = auto_amplitude_gradient; // Short alias
  wire any_short = lowside_short_phase_a || lowside_short_phase_b || ground_short_phase_a ||
    ground_short_phase_b;
  wire clear_req = chopper_off_time_setting == 4'h0 || driver_disable_pin;
  logic [31:0] idle_q = 32'h0; // Clocks since last step
  logic live_q = 1'b0; // Previous cycle out of reset
  logic seen_q = 1'b0; // A step has occurred
  //////////////////////////////
  // Helper counters
  always @(posedge clk) begin
    idle_q <= (rst || step_pulse) ? 32'h0 : idle_q + 32'h1;
    live_q <= !rst;
    seen_q <= !rst && (seen_q || step_pulse);
  end
  sequence short_seen;
    any_short;
  endsequence
  sequence clear_only;
    clear_req && !any_short;
  endsequence
  //////////////////////////////
  temp_follow_a: assert property (live_q |-> sf[9:8] == $past({temp_cmp_high_mid, temp_cmp_low}))
    else $error("temperature bits do not follow comparators");
  prewarn_follow_a: assert property (live_q |-> sf[0] == $past(prewarn_cmp))
    else $error("prewarning bit does not follow comparator");
  short_kill_a: assert property (short_seen |=> !bridge_enable)
    else $error("bridge stays on after short");
  short_clear_a: assert property (clear_only |=> sf[5:2] == 4'h0)
    else $error("short flags not cleared");
  short_hold_a: assert property ((sf[5:2] != 4'h0 && !clear_req) ##1 $stable(voltage_mode) |-> sf[5:2] != 4'h0)
    else $error("short flags dropped while latched");
  overheat_kill_a: assert property (overheat_cmp |=> sf[1] && !bridge_enable)
    else $error("overheat not flagged or bridge on");
  overheat_hold_a: assert property (sf[1] && prewarn_cmp |=> sf[1] && !bridge_enable)
    else $error("overheat released before prewarning cleared");
  early_stand_a: assert property (idle_q + 32'h1 < STANDSTILL_CLKS |-> !standstill)
    else $error("standstill too early");
  late_stand_a: assert property (seen_q && idle_q > STANDSTILL_CLKS + 32'h1 |-> standstill)
    else $error("standstill too late");
  grad_frozen_a: assert property (!tuning_phase_gradient && !grad_load |=> $stable(g))
    else $error("gradient moved outside its phase");
  grad_unit_a: assert property (live_q && !$past(grad_load) && $changed(g) |-> g == $past(g) + 8'h01 || g == $past(g) - 8'h01)
    else $error("gradient moved by more than one");
endmodule
bind voltage_pwm_autotune_status autotune_checker #(.STANDSTILL_CLKS(STANDSTILL_CLKS)) chk (
  .clk, .rst, .temp_cmp_high_mid, .temp_cmp_low, .overheat_cmp, .prewarn_cmp,
  .lowside_short_phase_b, .lowside_short_phase_a, .ground_short_phase_b, .ground_short_phase_a,
  .chopper_off_time_setting, .driver_disable_pin, .voltage_mode, .step_pulse, .grad_load,
  .driver_status_flags, .bridge_enable, .standstill, .auto_amplitude_gradient,
  .tuning_phase_gradient);
`default_nettype wire

// file: bench/step_source.sv
// Motion controller model issuing spaced step pulses
`timescale 1ns/1ns
`default_nettype none
module step_source (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] period,
  output var logic step_pulse = 1'b0,
  output var logic fullstep = 1'b0
);
  logic [7:0] cnt_q = 8'h00; // Clocks within one step period
  // One step every period plus one clocks while go, quiet otherwise
  // slow spaced steps
  always @(posedge clk) begin
    cnt_q <= (go && cnt_q != period) ? cnt_q + 8'h01 : 8'h00;
    step_pulse <= go && cnt_q == period;
    fullstep <= go && cnt_q == period;
  end
endmodule
`default_nettype wire

// file: bench/voltage_pwm_autotune_status_tb.sv
// Testbench for status flags, protection and tuning
`timescale 1ns/1ns
`default_nettype none
module voltage_pwm_autotune_status_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic temp_cmp_high_mid, temp_cmp_low, overheat_cmp, prewarn_cmp, open_load_b, open_load_a;
  logic driver_disable_pin, powerdown_serial_pin, voltage_mode, supply_changed, grad_load;
  logic grad_up, grad_down, go;
  logic [3:0] chopper_off_time_setting, shorts;
  logic [4:0] run_current_setting, hold_current_setting;
  logic [8:0] summed_amplitude_scale;
  logic [7:0] measured_offset, grad_load_value, period;
  wire lowside_short_phase_b, lowside_short_phase_a, ground_short_phase_b, ground_short_phase_a;
  wire step_pulse, fullstep, bridge_enable, standstill, offset_valid;
  wire tuning_phase_offset, tuning_phase_gradient;
  wire [31:0] driver_status_flags;
  wire [4:0] current_scale;
  wire [7:0] auto_amplitude_offset, auto_amplitude_gradient;
  integer bad_count = 0, tests_run = 0, i, n;
  logic [31:0] seed = 32'h431069e1;
  assign {lowside_short_phase_b, lowside_short_phase_a, ground_short_phase_b,
    ground_short_phase_a} = shorts;
  voltage_pwm_autotune_status #(.STANDSTILL_CLKS(32'h10), .OFFSET_PHASE_CLKS(32'h20),
    .STEPS_PER_UNIT(4'h8)) dut (.clk, .rst, .temp_cmp_high_mid, .temp_cmp_low, .overheat_cmp,
    .prewarn_cmp, .open_load_b, .open_load_a, .lowside_short_phase_b, .lowside_short_phase_a,
    .ground_short_phase_b, .ground_short_phase_a, .chopper_off_time_setting, .driver_disable_pin,
    .powerdown_serial_pin, .voltage_mode, .run_current_setting, .hold_current_setting,
    .step_pulse, .fullstep, .summed_amplitude_scale, .measured_offset, .supply_changed,
    .grad_load, .grad_load_value, .grad_up, .grad_down, .driver_status_flags, .bridge_enable,
    .standstill, .current_scale, .auto_amplitude_offset, .auto_amplitude_gradient,
    .tuning_phase_offset, .tuning_phase_gradient, .offset_valid);
  step_source mc (.clk, .go, .period, .step_pulse, .fullstep);
  //////////////////////////////
  // Clock and helpers
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Expected word from {hi, lo, open b, open a, prewarn}
  function automatic logic [31:0] live_bits(input logic [4:0] v);
    return {22'h0, v[4:1], 5'h00, v[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////
  // Main sequence
  initial begin
    {temp_cmp_high_mid, temp_cmp_low, overheat_cmp, prewarn_cmp, open_load_b, open_load_a,
      driver_disable_pin, powerdown_serial_pin, supply_changed, grad_load, grad_up, grad_down,
      go, shorts} <= '0;
    {voltage_mode, chopper_off_time_setting, run_current_setting, hold_current_setting} <=
      {1'b1, 4'h3, 5'h1f, 5'h08};
    {summed_amplitude_scale, measured_offset, grad_load_value, period} <=
      {9'h050, 8'h20, 8'h00, 8'h40};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(auto_amplitude_gradient, 32'h0e);
    check(driver_status_flags, 32'h0);
    // Random comparator levels
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      seed = xorshift(seed);
      {temp_cmp_high_mid, temp_cmp_low, open_load_b, open_load_a, prewarn_cmp} <= seed[4:0];
      @(posedge clk);
      #1;
      check(driver_status_flags, live_bits(seed[4:0]));
      check(bridge_enable, 32'h1);
    end
    // Each short, mode switch, then alternate clears
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      shorts <= 4'h8 >> i;
      @(posedge clk);
      shorts <= 4'h0;
      #1;
      check(driver_status_flags[5:2], 4'h8 >> i);
      @(posedge clk);
      voltage_mode <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(driver_status_flags[5:2], 4'h0);
      voltage_mode <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check(driver_status_flags[5:2], 4'h8 >> i);
      check(bridge_enable, 32'h0);
      if (i[0]) driver_disable_pin <= 1'b1;
      else chopper_off_time_setting <= 4'h0;
      @(posedge clk);
      {driver_disable_pin, chopper_off_time_setting} <= {1'b0, 4'h3};
      #1;
      check(driver_status_flags[5:2], 4'h0);
    end
    // Overheat held until prewarning clears
    @(posedge clk);
    {overheat_cmp, prewarn_cmp} <= 2'b11;
    @(posedge clk);
    overheat_cmp <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(driver_status_flags[1:0], 2'b11);
    check(bridge_enable, 32'h0);
    prewarn_cmp <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(driver_status_flags[1:0], 2'b00);
    check(bridge_enable, 32'h1);
    check(current_scale, 32'h08);
    // Slow steps with reduction on until the offset phase completes
    {go, n} <= {1'b1, 32'h0};
    for (i = 0; i < 2000 && offset_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (tuning_phase_gradient === 1'b1) n++;
      if (tuning_phase_offset === 1'b1 && current_scale !== 5'h1f) n++;
    end
    check(n, 32'h0);
    check(offset_valid, 32'h1);
    check(auto_amplitude_offset, 32'h20);
    repeat (2) @(posedge clk);
    #1;
    check(current_scale, 32'h08);
    if (offset_valid !== 1'b1) tally_and_finish();
    // Fast motion inside the scale window, sixteen counted fullsteps
    {period, grad_up, n} <= {8'h04, 1'b1, 32'h0};
    for (i = 0; i < 2000 && n < 16; i++) begin
      @(negedge clk);
      if (fullstep === 1'b1 && tuning_phase_gradient === 1'b1) n++;
    end
    @(posedge clk);
    // ramp down to slow steps before stopping
    {period, grad_up} <= {8'h40, 1'b0};
    check(n, 32'h10);
    repeat (80) @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(auto_amplitude_gradient, 32'h10);
    // Preloaded gradient, supply change, rerun
    seed = xorshift(seed);
    {grad_load, grad_load_value} <= {1'b1, seed[7:0]};
    @(posedge clk);
    {grad_load, supply_changed} <= 2'b01;
    #1;
    check(auto_amplitude_gradient, seed[7:0]);
    @(posedge clk);
    supply_changed <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(offset_valid, 32'h0);
    // long pause after motion lets the phase rerun
    for (i = 0; i < 300 && offset_valid !== 1'b1; i++) @(posedge clk);
    check(offset_valid, 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
